// ==== rtl/asc_consts.svh ====
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// memory geometry
`define ASC_ADDR_W 15
`define ASC_DATA_W 8
`define ASC_CHIPS 1

// clock rate in kHz and memory timing in ns
`define ASC_CLK_KHZ 20000
`define ASC_T_CYCLE_NS 150
`define ASC_T_WPULSE_NS 80
`define ASC_T_ACCESS_NS 150
`define ASC_T_DIS_NS 45

// cycle counts: least times round up, none below one cycle
`define ASC_NS2CYC(ns) ((((ns) * `ASC_CLK_KHZ) + 999999) / 1000000)
`define ASC_CYC_WPULSE (`ASC_NS2CYC(`ASC_T_WPULSE_NS) + 1)
`define ASC_CYC_ACCESS (`ASC_NS2CYC(`ASC_T_ACCESS_NS) + 1)
`define ASC_CYC_TURN (`ASC_NS2CYC(`ASC_T_DIS_NS) + 1)

// pin idle levels
`define ASC_IDLE_HI 1'b1

`endif

// ==== rtl/asc_pkg.sv ====
package asc_pkg;
	typedef enum logic [2:0] {
		ASC_IDLE,
		ASC_WSETUP,
		ASC_WPULSE,
		ASC_WHOLD,
		ASC_RWAIT,
		ASC_RDONE,
		ASC_TURN
	} asc_state_t;

	typedef logic [7:0] asc_cnt_t;
endpackage

// ==== rtl/asc_sync3.sv ====
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_sync3 #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} asc_sync_t;

	asc_sync_t st_reg;
	asc_sync_t st_next;

	// a bit changes only once the second and third stages agree
	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++)
		begin
			if (st_reg.s2[i] == st_reg.s3[i])
				st_next.q[i] = st_reg.s3[i];
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign dout = st_reg.q;
endmodule

// ==== rtl/asc_sram_ctrl.sv ====
// Function
// - address stands before and through the whole write overlap.
// - data is captured at the first rising edge ending the overlap.
// - host releases the data bus whenever memory outputs are enabled.
// - with several chips, at most one select is active at once.
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_sram_ctrl
	import asc_pkg::*;
#(
	parameter int AW = `ASC_ADDR_W,
	parameter int DW = `ASC_DATA_W,
	parameter int CHIPS = `ASC_CHIPS,
	parameter int CSW = (CHIPS > 1) ? $clog2(CHIPS) : 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [CSW-1:0] reqChip,
	input wire logic [AW-1:0] reqAddr,
	input wire logic [DW-1:0] reqWdata,
	output logic reqReady,
	output logic rspValid,
	output logic [DW-1:0] rspRdata,
	output logic [AW-1:0] memAddr,
	output logic [CHIPS-1:0] memSel_n,
	output logic memWe_n,
	output logic memOe_n,
	output logic [DW-1:0] memDataOut,
	output logic memDataOe,
	input wire logic [DW-1:0] memDataIn
);
	import asc_pkg::*;

	localparam asc_cnt_t CYC_WPULSE = asc_cnt_t'(`ASC_CYC_WPULSE);
	localparam asc_cnt_t CYC_ACCESS = asc_cnt_t'(`ASC_CYC_ACCESS);
	localparam asc_cnt_t CYC_TURN = asc_cnt_t'(`ASC_CYC_TURN);

	typedef struct packed {
		asc_state_t state;
		asc_cnt_t cnt;
		logic ready;
		logic rvalid;
		logic [DW-1:0] rdata;
		logic [AW-1:0] addr;
		logic [CHIPS-1:0] sel_n;
		logic [CHIPS-1:0] selPend;
		logic we_n;
		logic oe_n;
		logic [DW-1:0] dout;
		logic doe;
	} asc_ctrl_t;

	asc_ctrl_t st_reg;
	asc_ctrl_t st_next;
	logic [DW-1:0] rdSync;

	// one-hot active-low select from the chip index
	function automatic logic [CHIPS-1:0] chipSel(input logic [CSW-1:0] idx);
		logic [CHIPS-1:0] s;
		s = '1;
		for (int i = 0; i < CHIPS; i++)
		begin
			if (CSW'(i) == idx)
				s[i] = 1'b0;
		end
		return s;
	endfunction

	// read data arrives from pins, so it is synchronised before capture
	asc_sync3 #(
		.W(DW)
	) i_asc_sync3 (
		.clk(clk),
		.arst_n(arst_n),
		.din(memDataIn),
		.dout(rdSync)
	);

	// access sequencer; only one request is outstanding at a time
	always_comb
	begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		if (st_reg.cnt != '0)
			st_next.cnt = st_reg.cnt - asc_cnt_t'(1);
		unique case (st_reg.state)
			ASC_IDLE:
			begin
				if (reqValid && st_reg.ready)
				begin
					st_next.ready = 1'b0;
					st_next.addr = reqAddr;
					st_next.oe_n = `ASC_IDLE_HI;
					// chip index taken now; the host may move it after this edge
					st_next.selPend = chipSel(reqChip);
					if (reqWrite)
					begin
						// address and data settle a cycle before the pulse
						st_next.dout = reqWdata;
						st_next.doe = 1'b1;
						st_next.state = ASC_WSETUP;
					end
					else
					begin
						// bus released before output enable falls
						st_next.doe = 1'b0;
						st_next.sel_n = chipSel(reqChip);
						st_next.oe_n = 1'b0;
						st_next.cnt = CYC_ACCESS;
						st_next.state = ASC_RWAIT;
					end
				end
			end
			ASC_WSETUP:
			begin
				// both lows start together, so memory never drives
				st_next.we_n = 1'b0;
				st_next.sel_n = st_reg.selPend;
				st_next.cnt = CYC_WPULSE;
				st_next.state = ASC_WPULSE;
			end
			ASC_WPULSE:
			begin
				if (st_reg.cnt == asc_cnt_t'(1))
				begin
					// write enable rises first and ends the overlap
					st_next.we_n = `ASC_IDLE_HI;
					st_next.state = ASC_WHOLD;
				end
			end
			ASC_WHOLD:
			begin
				// data and address held one cycle past the rising edge
				st_next.sel_n = '1;
				st_next.doe = 1'b0;
				st_next.state = ASC_TURN;
				st_next.cnt = asc_cnt_t'(1);
			end
			ASC_RWAIT:
			begin
				// wait covers access time plus the synchroniser depth
				if (st_reg.cnt == '0)
				begin
					st_next.state = ASC_RDONE;
					st_next.cnt = asc_cnt_t'(3);
				end
			end
			ASC_RDONE:
			begin
				if (st_reg.cnt == '0)
				begin
					st_next.rdata = rdSync;
					st_next.rvalid = 1'b1;
					st_next.oe_n = `ASC_IDLE_HI;
					st_next.sel_n = '1;
					st_next.cnt = CYC_TURN;
					st_next.state = ASC_TURN;
				end
			end
			ASC_TURN:
			begin
				// let memory outputs float before anyone drives again
				if (st_reg.cnt == '0)
				begin
					st_next.ready = 1'b1;
					st_next.state = ASC_IDLE;
				end
			end
			default:
			begin
				st_next.state = ASC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg <= '0;
			st_reg.state <= ASC_IDLE;
			st_reg.ready <= 1'b1;
			st_reg.sel_n <= '1;
			st_reg.we_n <= 1'b1;
			st_reg.oe_n <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// all outputs straight from the state register
	assign reqReady = st_reg.ready;
	assign rspValid = st_reg.rvalid;
	assign rspRdata = st_reg.rdata;
	assign memAddr = st_reg.addr;
	assign memSel_n = st_reg.sel_n;
	assign memWe_n = st_reg.we_n;
	assign memOe_n = st_reg.oe_n;
	assign memDataOut = st_reg.dout;
	assign memDataOe = st_reg.doe;
endmodule

// ==== verification/asc_sram_ctrl_assertions.sv ====
`timescale 1ns/1ps
module asc_chk #(
	parameter int CHIPS = 1,
	parameter int AW = 15,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [CHIPS-1:0] memSel_n,
	input wire logic [AW-1:0] memAddr,
	input wire logic memWe_n,
	input wire logic memOe_n,
	input wire logic [DW-1:0] memDataOut,
	input wire logic memDataOe
);
	logic ov;
	// write overlap: both strobes low
	assign ov = !memWe_n && !(&memSel_n);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_adr; ov && $past(ov) |-> $stable(memAddr); endproperty
	a_adr: assert property (p_adr) else $error("addr moved");
	property p_dat; $rose(memWe_n) && !(&memSel_n)
		|-> memDataOe && $stable(memDataOut); endproperty
	a_dat: assert property (p_dat) else $error("data lost");
	property p_bus; !memOe_n |-> !memDataOe; endproperty
	a_bus: assert property (p_bus) else $error("contention");
	property p_one; $countones(~memSel_n) <= 1; endproperty
	a_one: assert property (p_one) else $error("two selects");
	property p_oe; memDataOe |-> memOe_n; endproperty
	a_oe: assert property (p_oe) else $error("oe in write");
	// memory outputs need time to float before the host drives again
	property p_turn; $rose(memOe_n) |-> !memDataOe [*3]; endproperty
	a_turn: assert property (p_turn) else $error("bus too soon");
	// a select never falls ahead of write enable during a write
	property p_wfirst; $fell(&memSel_n) && memDataOe |-> !memWe_n;
	endproperty
	a_wfirst: assert property (p_wfirst) else $error("late we");
endmodule
bind asc_sram_ctrl asc_chk #(.CHIPS(CHIPS), .AW(AW), .DW(DW)) i_asc_chk (
	.clk(clk),
	.arst_n(arst_n), .memSel_n(memSel_n), .memAddr(memAddr),
	.memWe_n(memWe_n), .memOe_n(memOe_n), .memDataOut(memDataOut),
	.memDataOe(memDataOe));

// ==== verification/asc_sram_model.sv ====
`timescale 1ns/1ps
module asc_sram_model (
	input wire logic [14:0] addr,
	input wire logic sel_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [7:0] din,
	output logic [7:0] dq,
	output logic dqOe
);
	logic [7:0] mem [32768];
	logic noOut = 1'b0;
	wire ov = !sel_n && !we_n;
	// cell taken when the first strobe rises
	always @(negedge ov) mem[addr] = din;
	// early write enable blocks output for the whole access
	always @(posedge sel_n or negedge we_n) noOut = !we_n;
	assign dqOe = !sel_n && we_n && !oe_n && !noOut;
	// slow part; released pins show the inverse, not stale data
	assign #150 dq = dqOe ? mem[addr] : ~mem[addr];
endmodule

// ==== verification/asc_sram_ctrl_tb.sv ====
`timescale 1ns/1ps
module asc_sram_ctrl_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic reqValid = 1'b0;
	logic reqWrite = 1'b0;
	logic [14:0] reqAddr = 15'h0000;
	logic [7:0] reqWdata = 8'h00;
	logic reqReady, rspValid, memWe_n, memOe_n, memDataOe, devOe;
	logic [7:0] rspRdata, memDataOut, devDq, bus, v;
	logic [14:0] memAddr;
	logic [0:0] memSel_n;
	int num_errors = 0;
	int n_compared = 0;
	// resolved data pins
	assign bus = memDataOe ? memDataOut : devDq;
	always #25 clk = ~clk;
	asc_sram_ctrl i_asc_sram_ctrl (.clk(clk), .arst_n(arst_n),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqChip(1'b0),
		.reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
		.rspValid(rspValid), .rspRdata(rspRdata), .memAddr(memAddr),
		.memSel_n(memSel_n), .memWe_n(memWe_n), .memOe_n(memOe_n),
		.memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(bus));
	asc_sram_model i_asc_sram_model (.addr(memAddr), .sel_n(memSel_n[0]),
		.we_n(memWe_n), .oe_n(memOe_n), .din(bus), .dq(devDq), .dqOe(devOe));
	// memory never drives while the host does; sampled mid-cycle
	always @(negedge clk)
		if (memDataOe === 1'b1)
			chk({7'h00, devOe}, 8'h00);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a wait that runs out ends the run
	task automatic lim(input int n);
		if (n >= 40)
		begin
			num_errors++;
			test_done();
		end
	endtask
	task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		// one edge passes so a new request never lands on a release
		@(posedge clk);
		#1 reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqWdata = d;
		// ready is looked at settled, after the edge that set it
		while (reqReady !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1 n++;
		end
		lim(n);
		// the next edge takes the request
		@(posedge clk);
		#1 reqValid = 1'b0;
	endtask
	task automatic rd(input logic [14:0] a, output logic [7:0] r);
		int n;
		n = 0;
		req(1'b0, a, 8'h00);
		chk({4'h0, memSel_n, memWe_n, memOe_n, memDataOe}, 8'h04);
		while (rspValid !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1 n++;
		end
		lim(n);
		r = rspRdata;
	endtask
	task automatic t_idle;
		chk({3'h0, reqReady, memSel_n, memWe_n, memOe_n, memDataOe}, 8'h1E);
	endtask
	// extreme addresses, written back to back
	task automatic t_ends;
		req(1'b1, 15'h0000, 8'h5A);
		req(1'b1, 15'h7FFF, 8'hA5);
		rd(15'h7FFF, v);
		chk(v, 8'hA5);
		rd(15'h0000, v);
		chk(v, 8'h5A);
	endtask
	task automatic t_over;
		req(1'b1, 15'h1234, 8'hFF);
		req(1'b1, 15'h1234, 8'h00);
		req(1'b1, 15'h4321, 8'hC3);
		rd(15'h1234, v);
		chk(v, 8'h00);
		rd(15'h4321, v);
		chk(v, 8'hC3);
	endtask
	// pins seen through one write and one read
	task automatic t_pins;
		req(1'b1, 15'h2AAA, 8'h3C);
		chk(memAddr[7:0], 8'hAA);
		chk({1'b0, memAddr[14:8]}, 8'h2A);
		chk(memDataOut, 8'h3C);
		@(posedge clk);
		#1 chk({4'h0, memSel_n, memWe_n, memOe_n, memDataOe}, 8'h03);
		rd(15'h2AAA, v);
		chk(v, 8'h3C);
		chk({4'h0, memSel_n, memWe_n, memOe_n, memDataOe}, 8'h0E);
	endtask
	// reset before the strobes fall must leave the cell untouched
	task automatic t_reset;
		req(1'b1, 15'h1234, 8'h77);
		arst_n = 1'b0;
		@(posedge clk);
		#1 chk({3'h0, reqReady, memSel_n, memWe_n, memOe_n, memDataOe}, 8'h1E);
		arst_n = 1'b1;
		rd(15'h1234, v);
		chk(v, 8'h00);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		t_idle();
		t_ends();
		t_over();
		t_pins();
		t_reset();
		test_done();
	end
endmodule
